// >>> verilog/nes_map.svh
// Object offsets, field positions, reset values and codes of the error and parameter store
`ifndef NES_MAP_SVH
`define NES_MAP_SVH
`define NES_IDX_ERR_GROUP 16'h1001
`define NES_IDX_FAULT 16'h1002
`define NES_IDX_HISTORY 16'h1003
`define NES_IDX_SAVE 16'h1010
`define NES_IDX_RESTORE 16'h1011
`define NES_IDX_TPDO 16'h1800
`define NES_SUB_TPDO_TYPE 8'h02
`define NES_SUB_TPDO_MAX 8'h05
`define NES_SIG_SAVE 32'h65766173
`define NES_SIG_LOAD 32'h64616F6C
`define NES_GRP_ANY 0
`define NES_GRP_TEMP 3
`define NES_GRP_PROFILE 5
`define NES_FLT_X 0
`define NES_FLT_Y 1
`define NES_FLT_TLOW 4
`define NES_FLT_THIGH 5
`define NES_FLT_NV 8
`define NES_CODE_TEMP 16'h4200
`define NES_CODE_HW 16'h5000
`define NES_CODE_DEV 16'hFF00
`define NES_TPDO_TYPE_RST 8'hFE
`define NES_TPDO_SYNC_MIN 8'h01
`define NES_TPDO_SYNC_MAX 8'hF0
`define NES_TPDO_ASYNC 8'hFE
`define NES_HIST_DEPTH 5
`endif

// >>> verilog/nes_pkg.sv
// Types shared by the error and parameter store
package nes_pkg;
   typedef enum logic [0:0] {
      NES_EM_IDLE = 1'b0,
      NES_EM_SEND = 1'b1
   } nes_em_e;

   // Object access request from the service data handler
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] wdata;
   } nes_od_req_s;

   // Emergency message contents
   typedef struct packed {
      logic [15:0] code;
      logic [7:0] group;
      logic [15:0] fault;
   } nes_emcy_s;

   // Whole block state
   typedef struct packed {
      logic [7:0] group;
      logic [31:0] fault;
      logic [2:0] pend;
      nes_em_e em;
      nes_emcy_s emcy;
      logic [4:0][31:0] hist;
      logic [2:0] count;
      logic [7:0] tpdo_type;
      logic restore_pend;
      logic [31:0] rdata;
      logic ack;
      logic err;
      logic save_req;
      logic load_req;
      logic reload_all;
      logic reload_comm;
      logic tpdo_fire;
      logic [15:0] x_out;
      logic [15:0] y_out;
   } nes_state_s;
endpackage : nes_pkg

// >>> verilog/nes_core.sv
// Error reporting, error history, parameter store trigger and TPDO1 trigger selection
//
// Operation
// - Group bit 0 set while any error active
// - Group bit 3 on temperature limit violation
// - Group bit 5 flags sensor error only
// - Emergency carries current group register
// - Fault low half into emergency and history
// - Fault bits 0/1 for axis range exceed
// - Clamp out-of-range axis to range end
// - Fault bits 4/5 temperature, zero when unsupervised
// - Fault bit 8 on corrupt nonvolatile data
// - Keep five entries, subindex zero counts
// - Newest at subindex one, oldest dropped
// - New error pushes history and emergency
// - Entry codes 4200h, 5000h, FF00h plus snapshot
// - Writing zero count clears history
// - Parameter writes apply at once
// - Save signature copies parameters to memory
// - Load signature writes defaults to memory
// - Defaults apply on application or comm reset
// - Acknowledge store at once, write later
// - Synchronous type sends only on SYNC
// - Type 254 enables cyclic or angle-change send
// - Supervision enable gates temperature flags
`timescale 1ns/1ns
`include "nes_map.svh"

module nes_core #(
   parameter logic signed [15:0] INCL_MIN = -16'sd4500,
   parameter logic signed [15:0] INCL_MAX = 16'sd4500
) (
   input wire logic i_clk,
   input wire logic i_rst,
   // Object access from the service data handler
   input wire logic i_od_wr,
   input wire logic i_od_rd,
   input wire logic [15:0] i_od_index,
   input wire logic [7:0] i_od_sub,
   input wire logic [31:0] i_od_wdata,
   output logic [31:0] o_od_rdata,
   output logic o_od_ack,
   output logic o_od_err,
   // Sensor side
   input wire logic signed [15:0] i_x_raw,
   input wire logic signed [15:0] i_y_raw,
   input wire logic signed [7:0] i_temp,
   input wire logic i_temp_mon_en,
   input wire logic signed [7:0] i_temp_lo,
   input wire logic signed [7:0] i_temp_hi,
   output logic [15:0] o_x_incl,
   output logic [15:0] o_y_incl,
   // Nonvolatile memory controller
   input wire logic i_nv_corrupt,
   output logic o_nv_save,
   output logic o_nv_load,
   // Network management resets and reload
   input wire logic i_reset_app,
   input wire logic i_reset_comm,
   output logic o_reload_all,
   output logic o_reload_comm,
   // Emergency transmitter
   input wire logic i_emcy_ready,
   output logic o_emcy_valid,
   output logic [15:0] o_emcy_code,
   output logic [7:0] o_emcy_group,
   output logic [15:0] o_emcy_fault,
   // TPDO1 triggering
   input wire logic i_sync,
   input wire logic i_cyclic_tick,
   input wire logic i_angle_change,
   output logic o_tpdo_fire,
   output logic o_tpdo_sync_mode,
   output logic o_tpdo_async_mode
);
   nes_pkg::nes_state_s st_r;
   nes_pkg::nes_state_s st_nxt;
   nes_pkg::nes_od_req_s req;

   // ==================================================================
   // Live fault detection
   // Live conditions lead the registered flags by one cycle
   logic x_over;
   logic x_low;
   logic y_over;
   logic y_low;
   logic t_low;
   logic t_high;
   logic nv_flag_r;
   logic [31:0] fault_now;
   logic [7:0] group_now;
   logic [2:0] class_now;
   logic [2:0] class_old;
   logic [2:0] rise;

   // Strict compares: a value equal to a range end is still in range
   assign x_low = i_x_raw < INCL_MIN;
   assign y_low = i_y_raw < INCL_MIN;
   assign x_over = x_low || (i_x_raw > INCL_MAX);
   assign y_over = y_low || (i_y_raw > INCL_MAX);
   assign t_low = i_temp_mon_en && (i_temp < i_temp_lo);
   assign t_high = i_temp_mon_en && (i_temp > i_temp_hi);

   // Nonvolatile fault stays until reset: a corrupt read has no clearing event
   // Covers store, restore and power-on loading alike
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         nv_flag_r <= 1'b0;
      end else if (i_nv_corrupt) begin
         nv_flag_r <= 1'b1;
      end
   end

   // Fault word and group register from live conditions; unused bits zero
   // Group bit 0 covers every fault, the memory fault included
   always_comb begin
      fault_now = 32'h0;
      fault_now[`NES_FLT_X] = x_over;
      fault_now[`NES_FLT_Y] = y_over;
      fault_now[`NES_FLT_TLOW] = t_low;
      fault_now[`NES_FLT_THIGH] = t_high;
      fault_now[`NES_FLT_NV] = nv_flag_r;
      group_now = 8'h0;
      group_now[`NES_GRP_TEMP] = t_low || t_high;
      group_now[`NES_GRP_PROFILE] = x_over || y_over;
      group_now[`NES_GRP_ANY] = |fault_now;
   end

   // Error classes: 0 temperature, 1 hardware, 2 device specific
   assign class_now = {x_over || y_over, nv_flag_r, t_low || t_high};
   assign class_old = {st_r.fault[`NES_FLT_X] || st_r.fault[`NES_FLT_Y],
                       st_r.fault[`NES_FLT_NV],
                       st_r.fault[`NES_FLT_TLOW] || st_r.fault[`NES_FLT_THIGH]};
   // Rise against the registered flags, so a lasting fault reports only once
   assign rise = class_now & ~class_old;

   // ==================================================================
   // Request bundle from the object port
   assign req.wr = i_od_wr;
   assign req.rd = i_od_rd;
   assign req.index = i_od_index;
   assign req.sub = i_od_sub;
   assign req.wdata = i_od_wdata;

   // ==================================================================
   // Next-state logic
   always_comb begin
      logic [2:0] pend_all;
      logic [15:0] code;
      logic [2:0] take;
      logic [3:0] slot;
      pend_all = 3'h0;
      code = 16'h0;
      take = 3'h0;
      slot = 4'h0;
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.err = 1'b0;
      st_nxt.save_req = 1'b0;
      st_nxt.load_req = 1'b0;
      st_nxt.reload_all = 1'b0;
      st_nxt.reload_comm = 1'b0;

      // Flags follow their conditions; all but the sticky nonvolatile flag clear by themselves
      st_nxt.fault = fault_now;
      st_nxt.group = group_now;

      // Clamp to the nearest range end while out of range
      // Inside the range the raw value passes through unchanged
      st_nxt.x_out = x_over ? (x_low ? INCL_MIN : INCL_MAX) : i_x_raw;
      st_nxt.y_out = y_over ? (y_low ? INCL_MIN : INCL_MAX) : i_y_raw;

      // Pending new errors; a new rise is kept even while another is served
      pend_all = st_r.pend | rise;

      // History clear by writing zero to the count
      // A push in the same cycle is applied after the clear and survives
      if (req.wr && req.index == `NES_IDX_HISTORY && req.sub == 8'h00) begin
         if (req.wdata == 32'h0) begin
            st_nxt.count = 3'h0;
            st_nxt.hist = '0;
         end else begin
            st_nxt.err = 1'b1;
         end
      end

      // Emergency engine: one error class per message, temperature first
      // Only one message is in flight; classes rising meanwhile wait in pend
      // Priority runs temperature, then hardware, then axis faults
      unique case (st_r.em)
         nes_pkg::NES_EM_IDLE: begin
            if (pend_all != 3'h0) begin
               if (pend_all[0]) begin
                  code = `NES_CODE_TEMP;
                  take = 3'b001;
               end else if (pend_all[1]) begin
                  code = `NES_CODE_HW;
                  take = 3'b010;
               end else begin
                  code = `NES_CODE_DEV;
                  take = 3'b100;
               end
               st_nxt.emcy.code = code;
               st_nxt.emcy.group = group_now;
               st_nxt.emcy.fault = fault_now[15:0];
               st_nxt.em = nes_pkg::NES_EM_SEND;
               // Push newest at the front; the oldest falls off the end
               for (int i = `NES_HIST_DEPTH - 1; i > 0; i--) begin
                  st_nxt.hist[i] = st_nxt.hist[i-1];
               end
               st_nxt.hist[0] = {fault_now[15:0], code};
               // Count saturates at the depth once the oldest starts to drop
               if (st_nxt.count < 3'(`NES_HIST_DEPTH)) begin
                  st_nxt.count = st_nxt.count + 3'h1;
               end
            end
         end
         nes_pkg::NES_EM_SEND: begin
            if (i_emcy_ready) begin
               st_nxt.em = nes_pkg::NES_EM_IDLE;
            end
         end
      endcase
      st_nxt.pend = pend_all & ~take;

      // Object writes: store, restore and transmission type
      // Read-only objects fall to the default branch and are refused
      if (req.wr) begin
         st_nxt.ack = 1'b1;
         unique case (req.index)
            `NES_IDX_HISTORY: begin
               if (req.sub != 8'h00) begin
                  st_nxt.err = 1'b1;
               end
            end
            `NES_IDX_SAVE: begin
               // Answered at once; the memory writes in the background
               if (req.sub == 8'h01 && req.wdata == `NES_SIG_SAVE) begin
                  st_nxt.save_req = 1'b1;
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            `NES_IDX_RESTORE: begin
               if (req.sub == 8'h01 && req.wdata == `NES_SIG_LOAD) begin
                  st_nxt.load_req = 1'b1;
                  st_nxt.restore_pend = 1'b1;
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            `NES_IDX_TPDO: begin
               if (req.sub == `NES_SUB_TPDO_TYPE) begin
                  st_nxt.tpdo_type = req.wdata[7:0];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            default: begin
               st_nxt.err = 1'b1;
            end
         endcase
      end

      // Object reads
      // Data is cleared first so a refused read never shows stale data
      if (req.rd) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdata = 32'h0;
         unique case (req.index)
            `NES_IDX_ERR_GROUP: begin
               st_nxt.rdata = {24'h0, st_r.group};
            end
            `NES_IDX_FAULT: begin
               st_nxt.rdata = st_r.fault;
            end
            `NES_IDX_HISTORY: begin
               if (req.sub == 8'h00) begin
                  st_nxt.rdata = {29'h0, st_r.count};
               end else if (req.sub <= {5'h0, st_r.count}) begin
                  // Subindex n sits in storage slot n-1
                  slot = 4'(req.sub - 8'h01);
                  st_nxt.rdata = st_r.hist[slot];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            `NES_IDX_SAVE, `NES_IDX_RESTORE: begin
               if (req.sub == 8'h00) begin
                  st_nxt.rdata = 32'h1;
               end else if (req.sub != 8'h01) begin
                  st_nxt.err = 1'b1;
               end
            end
            `NES_IDX_TPDO: begin
               if (req.sub == 8'h00) begin
                  st_nxt.rdata = {24'h0, `NES_SUB_TPDO_MAX};
               end else if (req.sub == `NES_SUB_TPDO_TYPE) begin
                  st_nxt.rdata = {24'h0, st_r.tpdo_type};
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            default: begin
               st_nxt.err = 1'b1;
            end
         endcase
      end

      // Restored defaults take effect only at the next reset command
      // A load written in the same cycle as the reset stays pending: the set wins
      if (i_reset_app) begin
         st_nxt.reload_all = st_r.restore_pend;
         st_nxt.restore_pend = st_nxt.load_req;
         if (st_r.restore_pend) begin
            st_nxt.tpdo_type = `NES_TPDO_TYPE_RST;
         end
      end else if (i_reset_comm) begin
         // Only the communication defaults apply; the load stays pending
         st_nxt.reload_comm = st_r.restore_pend;
         if (st_r.restore_pend) begin
            st_nxt.tpdo_type = `NES_TPDO_TYPE_RST;
         end
      end

      // TPDO1 trigger by transmission type
      // Types outside both ranges never fire the object
      st_nxt.tpdo_fire = 1'b0;
      if (st_r.tpdo_type >= `NES_TPDO_SYNC_MIN && st_r.tpdo_type <= `NES_TPDO_SYNC_MAX) begin
         st_nxt.tpdo_fire = i_sync;
      end else if (st_r.tpdo_type == `NES_TPDO_ASYNC) begin
         st_nxt.tpdo_fire = i_cyclic_tick || i_angle_change;
      end
   end

   // ==================================================================
   // State register
   // Reset leaves the transmit trigger in the asynchronous mode
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r <= '0;
         st_r.em <= nes_pkg::NES_EM_IDLE;
         st_r.tpdo_type <= `NES_TPDO_TYPE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==================================================================
   // Outputs
   // Object port answer, registered
   assign o_od_rdata = st_r.rdata;
   assign o_od_ack = st_r.ack;
   assign o_od_err = st_r.err;
   // Clamped inclination
   assign o_x_incl = st_r.x_out;
   assign o_y_incl = st_r.y_out;
   // Memory and reset requests, one-cycle pulses
   assign o_nv_save = st_r.save_req;
   assign o_nv_load = st_r.load_req;
   assign o_reload_all = st_r.reload_all;
   assign o_reload_comm = st_r.reload_comm;
   // Emergency fields stand until the transmitter accepts
   assign o_emcy_valid = (st_r.em == nes_pkg::NES_EM_SEND);
   assign o_emcy_code = st_r.emcy.code;
   assign o_emcy_group = st_r.emcy.group;
   assign o_emcy_fault = st_r.emcy.fault;
   // Transmit trigger and decoded mode
   assign o_tpdo_fire = st_r.tpdo_fire;
   assign o_tpdo_sync_mode = (st_r.tpdo_type >= `NES_TPDO_SYNC_MIN) && (st_r.tpdo_type <= `NES_TPDO_SYNC_MAX);
   assign o_tpdo_async_mode = (st_r.tpdo_type == `NES_TPDO_ASYNC);
endmodule : nes_core

// >>> tb/nes_core_sva.sv
// Port-level assertions for the error and parameter store
`timescale 1ns/1ns
`include "nes_map.svh"
module nes_core_sva #(
   parameter logic signed [15:0] INCL_MIN = -16'sd4500,
   parameter logic signed [15:0] INCL_MAX = 16'sd4500
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_od_wr,
   input wire logic [15:0] i_od_index,
   input wire logic [7:0] i_od_sub,
   input wire logic [31:0] i_od_wdata,
   input wire logic o_od_ack,
   input wire logic o_od_err,
   input wire logic signed [15:0] i_x_raw,
   input wire logic signed [15:0] i_y_raw,
   input wire logic [15:0] o_x_incl,
   input wire logic [15:0] o_y_incl,
   input wire logic o_nv_save,
   input wire logic o_nv_load,
   input wire logic i_emcy_ready,
   input wire logic o_emcy_valid,
   input wire logic [15:0] o_emcy_code,
   input wire logic [7:0] o_emcy_group,
   input wire logic [15:0] o_emcy_fault,
   input wire logic i_sync,
   input wire logic i_cyclic_tick,
   input wire logic o_tpdo_fire,
   input wire logic o_tpdo_sync_mode,
   input wire logic o_tpdo_async_mode
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==========
   // Trigger writes decoded once
   wire logic sv_w = i_od_wr && i_od_index == `NES_IDX_SAVE && i_od_sub == 8'h01;
   wire logic ld_w = i_od_wr && i_od_index == `NES_IDX_RESTORE && i_od_sub == 8'h01;
   // ==========
   // Store and restore
   AST_SAVE: assert property (sv_w && i_od_wdata == `NES_SIG_SAVE |=> o_od_ack && !o_od_err && o_nv_save)
      else $error("save signature not acknowledged with store pulse");
   AST_LOAD: assert property (ld_w && i_od_wdata == `NES_SIG_LOAD |=> o_od_ack && !o_od_err && o_nv_load)
      else $error("load signature not acknowledged with default write");
   AST_BAD_SIG: assert property (sv_w && i_od_wdata != `NES_SIG_SAVE |=> o_od_err && !o_nv_save)
      else $error("wrong save signature accepted");
   // ==========
   // Emergency contents
   AST_GROUP: assert property (o_emcy_valid |-> o_emcy_group[0] && (o_emcy_group & 8'hD6) == 8'h00)
      else $error("emergency group bits wrong");
   AST_EMCY_HOLD: assert property (o_emcy_valid && !i_emcy_ready |=> o_emcy_valid && $stable(o_emcy_code) &&
      $stable(o_emcy_group) && $stable(o_emcy_fault)) else $error("emergency changed before accept");
   // ==========
   // Transmit trigger and clamp
   AST_SYNC: assert property (o_tpdo_sync_mode && i_sync |=> o_tpdo_fire)
      else $error("no send after sync");
   AST_SYNC_ONLY: assert property (o_tpdo_fire && o_tpdo_sync_mode |-> $past(i_sync))
      else $error("send without sync in sync mode");
   AST_ASYNC: assert property (o_tpdo_async_mode && i_cyclic_tick |=> o_tpdo_fire)
      else $error("no send after cyclic tick");
   AST_CLAMP_X: assert property (i_x_raw > INCL_MAX |=> o_x_incl == INCL_MAX)
      else $error("x not clamped to maximum");
   AST_CLAMP_Y: assert property (i_y_raw < INCL_MIN |=> o_y_incl == INCL_MIN)
      else $error("y not clamped to minimum");
   C_EMCY: cover property (o_emcy_valid && i_emcy_ready);
   C_LOAD: cover property (o_nv_load);
   C_FIRE: cover property (o_tpdo_fire);
endmodule : nes_core_sva

// >>> tb/nes_master_model.sv
// Network master model: object access cycles and emergency acceptance
`timescale 1ns/1ns
module nes_master_model (
   input wire logic i_clk,
   input wire logic i_slow,
   input wire logic i_od_ack,
   input wire logic i_od_err,
   input wire logic [31:0] i_od_rdata,
   input wire logic i_emcy_valid,
   output logic o_od_wr,
   output logic o_od_rd,
   output logic [15:0] o_od_index,
   output logic [7:0] o_od_sub,
   output logic [31:0] o_od_wdata,
   output logic o_emcy_ready
);
   logic [1:0] wait_cnt = 2'h0;
   initial begin
      {o_od_wr, o_od_rd, o_od_index, o_od_sub, o_od_wdata, o_emcy_ready} = '0;
   end
   // ==========
   // One strobe, then inverted address and data so stale values never look valid
   task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
      output logic ack, output logic err, output logic [31:0] rd);
      @(negedge i_clk);
      o_od_wr = wr;
      o_od_rd = !wr;
      {o_od_index, o_od_sub, o_od_wdata} = {idx, sub, wd};
      @(negedge i_clk);
      // Answer stands for one cycle after the taking edge, so it is read here
      {ack, err, rd} = {i_od_ack, i_od_err, i_od_rdata};
      {o_od_wr, o_od_rd} = 2'h0;
      {o_od_index, o_od_sub, o_od_wdata} = ~{idx, sub, wd};
   endtask : acc
   // ==========
   // Emergency accept: at once, or after three cycles when slow
   always @(negedge i_clk) begin
      if (i_emcy_valid && !o_emcy_ready) begin
         wait_cnt <= wait_cnt + 2'h1;
         if (!i_slow || wait_cnt == 2'h3) o_emcy_ready <= 1'b1;
      end else begin
         o_emcy_ready <= 1'b0;
         wait_cnt <= 2'h0;
      end
   end
endmodule : nes_master_model

// >>> tb/tb.sv
// Self-checking bench for the error and parameter store
`timescale 1ns/1ns
module tb;
   logic i_clk = 1'b0, i_rst = 1'b1, i_slow = 1'b0, i_temp_mon_en = 1'b0, i_nv_corrupt = 1'b0;
   logic i_reset_app = 1'b0, i_reset_comm = 1'b0, i_sync = 1'b0, i_cyclic_tick = 1'b0, i_angle_change = 1'b0;
   logic signed [15:0] i_x_raw = 16'h0, i_y_raw = 16'h0;
   logic signed [7:0] i_temp = 8'h14, i_temp_lo = 8'hDD, i_temp_hi = 8'h4B;
   logic i_od_wr, i_od_rd, i_emcy_ready, o_od_ack, o_od_err, o_nv_save, o_nv_load, o_reload_all, o_reload_comm;
   logic [15:0] i_od_index, o_x_incl, o_y_incl, o_emcy_code, o_emcy_fault;
   logic [7:0] i_od_sub, o_emcy_group;
   logic [31:0] i_od_wdata, o_od_rdata, rd;
   logic o_emcy_valid, o_tpdo_fire, o_tpdo_sync_mode, o_tpdo_async_mode, ack, err;
   int n_fail = 0;
   int n_compared = 0;
   nes_core u_nes_core (.*);
   nes_master_model u_nes_master_model (.i_clk(i_clk), .i_slow(i_slow), .i_od_ack(o_od_ack), .i_od_err(o_od_err),
      .i_od_rdata(o_od_rdata), .i_emcy_valid(o_emcy_valid), .o_od_wr(i_od_wr), .o_od_rd(i_od_rd),
      .o_od_index(i_od_index), .o_od_sub(i_od_sub), .o_od_wdata(i_od_wdata), .o_emcy_ready(i_emcy_ready));
   // 50 MHz clock
   always #10 i_clk = ~i_clk;
   // ==========
   // Shared helpers
   task automatic test_done;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
      u_nes_master_model.acc(1'b1, i, s, d, ack, err, rd);
      chk("write ack", 32'h1, {31'h0, ack});
   endtask : wr
   task automatic rdo(input logic [15:0] i, input logic [7:0] s);
      u_nes_master_model.acc(1'b0, i, s, 32'h0, ack, err, rd);
   endtask : rdo
   // Bounded wait for an emergency, then its fields
   task automatic wait_em(input logic [15:0] c, input logic [15:0] f, input logic [7:0] g);
      int k;
      for (k = 0; k < 8 && o_emcy_valid !== 1'b1; k++) @(negedge i_clk);
      chk("emcy seen", 32'h1, {31'h0, k < 8});
      if (k == 8) test_done();
      chk("emcy code", {16'h0, c}, {16'h0, o_emcy_code});
      chk("emcy fault", {16'h0, f}, {16'h0, o_emcy_fault});
      chk("emcy group", {24'h0, g}, {24'h0, o_emcy_group});
   endtask : wait_em
   task automatic x_err;
      i_x_raw = 16'h1195;
      wait_em(16'hFF00, 16'h0001, 8'h21);
      i_x_raw = 16'h0;
      repeat (2) @(negedge i_clk);
   endtask : x_err
   // Pulse one trigger input and look for a send within three cycles
   task automatic pulse(input logic [2:0] p, input logic e, input string nm);
      int n;
      n = 0;
      {i_sync, i_cyclic_tick, i_angle_change} = p;
      repeat (3) begin
         @(negedge i_clk);
         {i_sync, i_cyclic_tick, i_angle_change} = 3'h0;
         if (o_tpdo_fire === 1'b1) n++;
      end
      chk(nm, {31'h0, e}, {31'h0, n != 0});
   endtask : pulse
   // ==========
   // Scenarios
   task automatic t_reset;
      chk("async after reset", 32'h1, {31'h0, o_tpdo_async_mode});
      rdo(16'h1001, 8'h00); chk("group", 32'h0, rd);
      rdo(16'h1003, 8'h00); chk("count", 32'h0, rd);
      rdo(16'h1010, 8'h01); chk("save sub1", 32'h0, rd);
      rdo(16'h2000, 8'h00); chk("unmapped err", 32'h1, {31'h0, err});
      $display("t_reset done");
   endtask : t_reset
   task automatic t_axis;
      x_err();
      rdo(16'h1003, 8'h01); chk("entry1", 32'h0001FF00, rd);
      i_slow = 1'b1;
      i_x_raw = 16'h1195;
      @(negedge i_clk);
      chk("x clamp", 32'h1194, {16'h0, o_x_incl});
      i_x_raw = 16'h0;
      // Let the slow accept of the clamp error finish first
      repeat (4) @(negedge i_clk);
      i_y_raw = 16'hEE6B;
      wait_em(16'hFF00, 16'h0002, 8'h21);
      chk("y clamp", 32'hEE6C, {16'h0, o_y_incl});
      i_y_raw = 16'h0;
      i_slow = 1'b0;
      repeat (6) @(negedge i_clk);
      rdo(16'h1002, 8'h00); chk("fault clear", 32'h0, rd);
      rdo(16'h1001, 8'h00); chk("group clear", 32'h0, rd);
      $display("t_axis done");
   endtask : t_axis
   task automatic t_temp;
      i_temp = 8'h50;
      repeat (3) @(negedge i_clk);
      rdo(16'h1002, 8'h00); chk("unsupervised", 32'h0, rd);
      i_temp_mon_en = 1'b1;
      wait_em(16'h4200, 16'h0020, 8'h09);
      i_temp = 8'h14;
      repeat (3) @(negedge i_clk);
      i_temp = 8'hD8;
      wait_em(16'h4200, 16'h0010, 8'h09);
      rdo(16'h1003, 8'h02); chk("entry2", 32'h00204200, rd);
      rdo(16'h1003, 8'h04); chk("entry4", 32'h0001FF00, rd);
      i_temp_mon_en = 1'b0;
      repeat (2) @(negedge i_clk);
      rdo(16'h1002, 8'h00); chk("gated", 32'h0, rd);
      i_temp = 8'h14;
      $display("t_temp done");
   endtask : t_temp
   task automatic t_hist;
      repeat (2) x_err();
      rdo(16'h1003, 8'h00); chk("count full", 32'h5, rd);
      rdo(16'h1003, 8'h05); chk("oldest", 32'h0002FF00, rd);
      rdo(16'h1003, 8'h06); chk("sub6 err", 32'h1, {31'h0, err});
      wr(16'h1003, 8'h00, 32'h1); chk("nonzero clear", 32'h1, {31'h0, err});
      wr(16'h1003, 8'h00, 32'h0); chk("clear ok", 32'h0, {31'h0, err});
      rdo(16'h1003, 8'h00); chk("count cleared", 32'h0, rd);
      $display("t_hist done");
   endtask : t_hist
   task automatic t_tpdo;
      logic [7:0] ty [4];
      ty = '{8'h01, 8'hF0, 8'hFE, 8'hF1};
      foreach (ty[j]) begin
         wr(16'h1800, 8'h02, {24'h0, ty[j]});
         rdo(16'h1800, 8'h02); chk("type", {24'h0, ty[j]}, rd);
         chk("sync mode", {31'h0, ty[j] <= 8'hF0}, {31'h0, o_tpdo_sync_mode});
         chk("async mode", {31'h0, ty[j] == 8'hFE}, {31'h0, o_tpdo_async_mode});
         pulse(3'h4, ty[j] <= 8'hF0, "sync send");
         pulse(3'h2, ty[j] == 8'hFE, "tick send");
         pulse(3'h1, ty[j] == 8'hFE, "angle send");
      end
      $display("t_tpdo done");
   endtask : t_tpdo
   task automatic t_nv;
      int k;
      wr(16'h1010, 8'h01, 32'h65766173); chk("save pulse", 32'h1, {31'h0, o_nv_save & !err});
      wr(16'h1010, 8'h01, 32'h65766174); chk("bad sig", 32'h1, {31'h0, err & !o_nv_save});
      wr(16'h1011, 8'h01, 32'h64616F6C); chk("load pulse", 32'h1, {31'h0, o_nv_load & !err});
      // Settle gap before any reset; a real memory needs far longer than this
      repeat (4) @(negedge i_clk);
      i_reset_comm = 1'b1;
      @(negedge i_clk);
      i_reset_comm = 1'b0;
      chk("reload comm", 32'h1, {31'h0, o_reload_comm & !o_reload_all});
      wr(16'h1800, 8'h02, 32'h000000F1);
      i_reset_app = 1'b1;
      @(negedge i_clk);
      i_reset_app = 1'b0;
      for (k = 0; k < 3 && o_reload_all !== 1'b1; k++) @(negedge i_clk);
      chk("reload all", 32'h1, {31'h0, k < 3});
      if (k == 3) test_done();
      @(negedge i_clk);
      chk("type default", 32'h1, {31'h0, o_tpdo_async_mode});
      i_nv_corrupt = 1'b1;
      @(negedge i_clk);
      i_nv_corrupt = 1'b0;
      wait_em(16'h5000, 16'h0100, 8'h01);
      rdo(16'h1002, 8'h00); chk("nv flag", 32'h100, rd);
      $display("t_nv done");
   endtask : t_nv
   // ==========
   // Main sequence
   initial begin
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      t_reset();
      t_axis();
      t_temp();
      t_hist();
      t_tpdo();
      t_nv();
      test_done();
   end
endmodule : tb
bind nes_core nes_core_sva #(.INCL_MIN(INCL_MIN), .INCL_MAX(INCL_MAX)) u_nes_core_sva (.*);
